/* File: rtl/pio_fmt_pkg.sv */
/*
 constants, field layouts and command codes for the programmed-I/O request formatter.
 assumes nothing of its surroundings.
*/
package pio_fmt_pkg;
	localparam int ADDR_W = 40;
	localparam int BUS_ADDR_W = 36;
	localparam int TID_W = 6;
	localparam int CREDIT_W = 4;
	localparam int NUM_CREDITS = 16;
	localparam int TAG_W = 16;
	localparam int ACK_TAG_W = 6;
	localparam int HDR_W = 64;
	// header field positions toward the bridge
	localparam int HDR_READ_BIT = 60;
	localparam int HDR_CREDIT_LO = 56;
	localparam int HDR_SIZE_LO = 48;
	localparam int HDR_PIOID_LO = 40;
	localparam int HDR_CMD_LO = 36;
	localparam logic [2:0] HDR_RSVD_TOP = 3'h7;
	// read size codes
	localparam logic [2:0] SZ_1B = 3'h0;
	localparam logic [2:0] SZ_2B = 3'h1;
	localparam logic [2:0] SZ_4B = 3'h2;
	localparam logic [2:0] SZ_8B = 3'h3;
	localparam logic [2:0] SZ_16B = 3'h4;
	localparam logic [2:0] WR_ADDR_CLR = 3'h0;
	// command mapping
	localparam logic [1:0] CMD_MEM64 = 2'h3;
	localparam logic [1:0] CMD_MEM32 = 2'h2;
	localparam logic [1:0] CMD_IO = 2'h1;
	localparam logic [1:0] CMD_CFG = 2'h0;
	typedef enum logic [1:0] {SPACE_MEM64, SPACE_MEM32, SPACE_IO, SPACE_CFG} space_t;
	// interrupt tag fields
	localparam int TAG_HI_TOP = 14;
	localparam int TAG_HI_BOT = 11;
	localparam int TAG_LO_TOP = 2;
	localparam int TAG_LO_BOT = 1;
	localparam int INT_DEPTH = 4;
endpackage

/* File: rtl/credit_if.sv */
/*
 carrier between the formatter and its credit pool.
 assumes a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface credit_if;
	logic take;
	logic avail;
	logic [pio_fmt_pkg::CREDIT_W-1:0] id;
	logic ret;
	logic [pio_fmt_pkg::CREDIT_W-1:0] ret_id;
	modport pool(input take, output avail, output id, input ret, input ret_id);
	modport user(output take, input avail, input id, output ret, output ret_id);
endinterface
`default_nettype wire

/* File: rtl/credit_pool.sv */
/*
 pool of credit identifiers bounding outstanding bridge transactions.
 assumes returned identifiers were previously handed out.
*/
`timescale 1ns/10ps
`default_nettype none
module credit_pool #(
	parameter int N = pio_fmt_pkg::NUM_CREDITS
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// credits
	credit_if.pool cr
);
	import pio_fmt_pkg::*;
	logic [N-1:0] free_ff;
	logic [N-1:0] nxt_free;
	logic [CREDIT_W-1:0] pick;
	logic found;

	always_comb begin
		pick = '0;
		found = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (free_ff[i]) begin
				pick = CREDIT_W'(i);
				found = 1'b1;
			end
		end
		nxt_free = free_ff;
		if (cr.take && found) begin
			nxt_free[pick] = 1'b0;
		end
		if (cr.ret) begin
			nxt_free[cr.ret_id] = 1'b1;
		end
	end

	assign cr.avail = found;
	assign cr.id = pick;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			free_ff <= '1;
		end else begin
			free_ff <= nxt_free;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/pio_request_formatter.sv */
/*
 programmed-I/O request formatter: turns crossbar requests into bridge headers,
 returns 16-byte read data, and answers external interrupts in arrival order.
 assumes requesters obey size and alignment, and the bridge returns credits.
*/
// Operation
// - read address names first wanted byte
// - always return sixteen bytes, replicate upper half below sixteen-byte size
// - no shifting of read data lanes
// - size codes one through sixteen bytes
// - sixteen-byte read returns all bits
// - byte mask forwarded unchanged
// - write payload forwarded unchanged
// - write address low three bits zeroed
// - mask bit seven is lane zero
// - every interrupt packet treated as external
// - interrupts answered in arrival order
// - four-bit credit per request, sixteen max
// - answer returns tag bits fourteen-eleven, two-one
// - two-bit command mapping by space
`timescale 1ns/10ps
`default_nettype none
module pio_request_formatter #(
	parameter int INT_DEPTH = pio_fmt_pkg::INT_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// request from processor_to_crossbar_bus
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_is_read,
	input wire logic [pio_fmt_pkg::ADDR_W-1:0] req_addr,
	input wire logic [7:0] req_size,
	input wire logic [pio_fmt_pkg::TID_W-1:0] req_thread,
	input wire logic [1:0] req_buf_id,
	input wire logic [63:0] req_wdata,
	input wire pio_fmt_pkg::space_t req_space,
	input wire logic [pio_fmt_pkg::BUS_ADDR_W-1:0] addr_mask,
	// header and payload to pcie_io_bridge
	output logic hdr_valid,
	input wire logic hdr_ready,
	output logic [pio_fmt_pkg::HDR_W-1:0] hdr_data,
	output logic [63:0] hdr_payload,
	// read return from pcie_io_bridge
	input wire logic rsp_valid,
	input wire logic [127:0] rsp_data,
	input wire logic [2:0] rsp_size,
	input wire logic [pio_fmt_pkg::TID_W-1:0] rsp_thread,
	input wire logic [pio_fmt_pkg::CREDIT_W-1:0] rsp_credit,
	// read return to crossbar
	output logic ret_valid,
	output logic [pio_fmt_pkg::TID_W-1:0] ret_thread,
	output logic [127:0] ret_data,
	// credit return for writes
	input wire logic wr_credit_ret,
	input wire logic [pio_fmt_pkg::CREDIT_W-1:0] wr_credit_id,
	// interrupt packets in
	input wire logic int_valid,
	output logic int_ready,
	input wire logic [pio_fmt_pkg::TAG_W-1:0] int_tag,
	// interrupt decision and answer to bridge
	input wire logic int_accept,
	input wire logic int_decide,
	output logic int_pending,
	output logic int_ack,
	output logic int_nack,
	output logic [pio_fmt_pkg::ACK_TAG_W-1:0] int_ack_tag
);
	import pio_fmt_pkg::*;

	// ==========================================================
	// credits
	credit_if cr();
	credit_pool #(.N(NUM_CREDITS)) u_pool (
		.clk(clk),
		.arst_n(arst_n),
		.cr(cr)
	);

	function automatic logic [1:0] cmd_of(input space_t s);
		unique case (s)
			SPACE_MEM64: cmd_of = CMD_MEM64;
			SPACE_MEM32: cmd_of = CMD_MEM32;
			SPACE_IO: cmd_of = CMD_IO;
			SPACE_CFG: cmd_of = CMD_CFG;
		endcase
	endfunction

	// ==========================================================
	// request formatting
	logic hdr_valid_ff, nxt_hdr_valid;
	logic [HDR_W-1:0] hdr_data_ff, nxt_hdr_data;
	logic [63:0] hdr_payload_ff, nxt_hdr_payload;
	logic take;
	logic [BUS_ADDR_W-1:0] baddr;

	assign req_ready = cr.avail && (!hdr_valid_ff || hdr_ready);
	assign take = req_valid && req_ready;
	assign cr.take = take;

	always_comb begin
		baddr = req_addr[BUS_ADDR_W-1:0] & addr_mask;
		if (!req_is_read) begin
			baddr[2:0] = WR_ADDR_CLR;
		end
		nxt_hdr_valid = hdr_valid_ff && !hdr_ready;
		nxt_hdr_data = hdr_data_ff;
		nxt_hdr_payload = hdr_payload_ff;
		if (take) begin
			nxt_hdr_valid = 1'b1;
			nxt_hdr_data = '0;
			nxt_hdr_data[HDR_W-1 -: 3] = HDR_RSVD_TOP;
			nxt_hdr_data[HDR_READ_BIT] = req_is_read;
			nxt_hdr_data[HDR_CREDIT_LO +: CREDIT_W] = cr.id;
			// read size code or write mask, passed as received
			nxt_hdr_data[HDR_SIZE_LO +: 8] = req_size;
			nxt_hdr_data[HDR_PIOID_LO +: 8] = {req_buf_id, req_thread};
			nxt_hdr_data[HDR_CMD_LO +: 2] = cmd_of(req_space);
			nxt_hdr_data[BUS_ADDR_W-1:0] = baddr;
			nxt_hdr_payload = req_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hdr_valid_ff <= 1'b0;
			hdr_data_ff <= '0;
			hdr_payload_ff <= '0;
		end else begin
			hdr_valid_ff <= nxt_hdr_valid;
			hdr_data_ff <= nxt_hdr_data;
			hdr_payload_ff <= nxt_hdr_payload;
		end
	end

	assign hdr_valid = hdr_valid_ff;
	assign hdr_data = hdr_data_ff;
	assign hdr_payload = hdr_payload_ff;

	// ==========================================================
	// read return
	logic ret_valid_ff, nxt_ret_valid;
	logic [TID_W-1:0] ret_thread_ff, nxt_ret_thread;
	logic [127:0] ret_data_ff, nxt_ret_data;

	always_comb begin
		nxt_ret_valid = rsp_valid;
		nxt_ret_thread = ret_thread_ff;
		nxt_ret_data = ret_data_ff;
		if (rsp_valid) begin
			nxt_ret_thread = rsp_thread;
			// lanes kept where the address put them
			if (rsp_size == SZ_16B) begin
				nxt_ret_data = rsp_data;
			end else begin
				nxt_ret_data = {rsp_data[127:64], rsp_data[127:64]};
			end
		end
	end

	assign cr.ret = rsp_valid || wr_credit_ret;
	assign cr.ret_id = rsp_valid ? rsp_credit : wr_credit_id;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ret_valid_ff <= 1'b0;
			ret_thread_ff <= '0;
			ret_data_ff <= '0;
		end else begin
			ret_valid_ff <= nxt_ret_valid;
			ret_thread_ff <= nxt_ret_thread;
			ret_data_ff <= nxt_ret_data;
		end
	end

	assign ret_valid = ret_valid_ff;
	assign ret_thread = ret_thread_ff;
	assign ret_data = ret_data_ff;

	// ==========================================================
	// external interrupt queue
	localparam int PW = $clog2(INT_DEPTH);
	logic [ACK_TAG_W-1:0] q_mem [INT_DEPTH];
	logic [PW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic ack_ff, nxt_ack, nack_ff, nxt_nack;
	logic [ACK_TAG_W-1:0] ack_tag_ff, nxt_ack_tag;
	logic q_empty, q_full, push, pop;

	assign q_empty = wp_ff == rp_ff;
	assign q_full = (wp_ff[PW-1:0] == rp_ff[PW-1:0]) && (wp_ff[PW] != rp_ff[PW]);
	assign int_ready = !q_full;
	assign push = int_valid && !q_full;
	assign pop = int_decide && !q_empty;
	assign int_pending = !q_empty;

	always_comb begin
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
		nxt_ack = pop && int_accept;
		nxt_nack = pop && !int_accept;
		nxt_ack_tag = pop ? q_mem[rp_ff[PW-1:0]] : ack_tag_ff;
	end

	always_ff @(posedge clk) begin
		if (push) begin
			q_mem[wp_ff[PW-1:0]] <= {int_tag[TAG_HI_TOP:TAG_HI_BOT],
				int_tag[TAG_LO_TOP:TAG_LO_BOT]};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			ack_ff <= 1'b0;
			nack_ff <= 1'b0;
			ack_tag_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
			ack_ff <= nxt_ack;
			nack_ff <= nxt_nack;
			ack_tag_ff <= nxt_ack_tag;
		end
	end

	assign int_ack = ack_ff;
	assign int_nack = nack_ff;
	assign int_ack_tag = ack_tag_ff;
endmodule
`default_nettype wire

/* File: tb/bridge_model.sv */
/*
 bridge side model: accepts headers, promptly or every other cycle.
 assumes one clock shared with the formatter.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic slow,
	output logic hdr_ready
);
	logic ph_ff;
	logic nxt_ph;
	// ====
	// acceptance pacing
	always_comb begin
		nxt_ph = !ph_ff;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_ff <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
		end
	end
	assign hdr_ready = !slow || ph_ff;
endmodule
`default_nettype wire

/* File: tb/pio_fmt_asserts.sv */
/*
 port checker for the request formatter.
 assumes binding to the top module.
*/
`timescale 1ns/10ps
`default_nettype none
module pio_fmt_asserts (
	// watched ports
	input wire logic clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic hdr_valid,
	input wire logic hdr_ready,
	input wire logic [63:0] hdr_data,
	input wire logic rsp_valid,
	input wire logic [2:0] rsp_size,
	input wire logic [127:0] rsp_data,
	input wire logic ret_valid,
	input wire logic [127:0] ret_data,
	input wire logic int_decide,
	input wire logic int_accept,
	input wire logic int_pending,
	input wire logic int_ack,
	input wire logic int_nack
);
	import pio_fmt_pkg::*;
	// ====
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_ans;
		int_decide && int_pending;
	endsequence
	AST_HOLD: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_data))
		else $error("header not held");
	AST_ISSUE: assert property (req_valid && req_ready |=> hdr_valid)
		else $error("no header after request");
	AST_WR_ADDR: assert property (hdr_valid && !hdr_data[HDR_READ_BIT] |-> hdr_data[2:0] == WR_ADDR_CLR)
		else $error("write address low bits set");
	AST_FULL: assert property (rsp_valid && rsp_size == SZ_16B |=> ret_valid && ret_data == $past(rsp_data))
		else $error("full read altered");
	AST_REPL: assert property (rsp_valid && rsp_size != SZ_16B |=> ret_valid && ret_data == {2{$past(rsp_data[127:64])}})
		else $error("upper half not copied");
	AST_RET_FOLLOW: assert property (rsp_valid |=> ret_valid)
		else $error("response not returned");
	AST_HDR_DROP: assert property (hdr_valid && hdr_ready && !(req_valid && req_ready) |=> !hdr_valid)
		else $error("header repeated");
	AST_RET_PULSE: assert property (!rsp_valid |=> !ret_valid)
		else $error("return without response");
	AST_ANSWER: assert property (s_ans |=> int_ack != int_nack)
		else $error("interrupt not answered");
	AST_ACK: assert property (s_ans ##0 int_accept |=> int_ack)
		else $error("accept not acked");
	AST_NACK: assert property (s_ans ##0 !int_accept |=> int_nack)
		else $error("refusal not nacked");
	AST_ONE_ANSWER: assert property (!(int_ack && int_nack))
		else $error("ack and nack together");
endmodule
bind pio_request_formatter pio_fmt_asserts u_chk (.clk, .arst_n, .req_valid, .req_ready,
	.hdr_valid, .hdr_ready, .hdr_data, .rsp_valid, .rsp_size, .rsp_data, .ret_valid,
	.ret_data, .int_decide, .int_accept, .int_pending, .int_ack, .int_nack);
`default_nettype wire

/* File: tb/pio_request_formatter_test.sv */
/*
 self-checking bench for the request formatter.
 assumes the bridge model on the header side.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("Error %0t: got %h want %h", $time, a, b); end end
module pio_request_formatter_test;
	import pio_fmt_pkg::*;
	localparam logic [35:0] MASK = 36'h0_ffff_ffff;
	logic clk, arst_n, req_valid, req_ready, req_is_read, hdr_valid, hdr_ready, slow, rsp_valid;
	logic ret_valid, wr_credit_ret, int_valid, int_ready, int_accept, int_decide, int_pending;
	logic int_ack, int_nack;
	logic [39:0] req_addr;
	logic [7:0] req_size;
	logic [5:0] req_thread, rsp_thread, ret_thread, int_ack_tag;
	logic [1:0] req_buf_id;
	logic [63:0] req_wdata, hdr_data, hdr_payload;
	space_t req_space;
	logic [35:0] addr_mask;
	logic [127:0] rsp_data, ret_data;
	logic [2:0] rsp_size;
	logic [3:0] rsp_credit, wr_credit_id;
	logic [15:0] int_tag;
	int errors, comparisons;
	pio_request_formatter u_dut (.clk, .arst_n, .req_valid, .req_ready, .req_is_read, .req_addr,
		.req_size, .req_thread, .req_buf_id, .req_wdata, .req_space, .addr_mask, .hdr_valid,
		.hdr_ready, .hdr_data, .hdr_payload, .rsp_valid, .rsp_data, .rsp_size, .rsp_thread,
		.rsp_credit, .ret_valid, .ret_thread, .ret_data, .wr_credit_ret, .wr_credit_id,
		.int_valid, .int_ready, .int_tag, .int_accept, .int_decide, .int_pending, .int_ack,
		.int_nack, .int_ack_tag);
	bridge_model u_bridge (.clk, .arst_n, .slow, .hdr_ready);
	// ====
	// tasks
	task automatic end_sim;
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo(input logic ok);
		if (ok !== 1'b1) begin
			errors++;
			$display("Error %0t: timeout", $time);
			end_sim();
		end
	endtask
	task automatic req(input logic rd, input logic [7:0] sz, input logic [39:0] a,
			input space_t sp, input logic [63:0] wd, input logic [3:0] cr);
		int n;
		logic [35:0] ea;
		ea = a[35:0] & MASK;
		if (!rd) ea[2:0] = 3'h0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_is_read <= rd;
		req_size <= sz;
		req_addr <= a;
		req_space <= sp;
		req_wdata <= wd;
		n = 0;
		do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 64);
		tmo(req_ready);
		req_valid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while ((hdr_valid && hdr_ready) !== 1'b1 && n < 64);
		tmo(hdr_valid && hdr_ready);
		`CHK(hdr_data, {3'h7, rd, cr, sz, 8'h2a, 2'h0, ~sp, ea})
		if (!rd) `CHK(hdr_payload, wd)
	endtask
	task automatic t_reqs;
		for (int i = 0; i < 5; i++) begin
			slow <= i[0];
			// aligned per size, odd only for one byte
			req(1'b1, {5'h1f, 3'(i)}, i == 0 ? 40'hf8_1234_5613 : 40'hf8_1234_5610,
				space_t'(i % 4), 64'h0, 4'(i));
		end
		slow <= 1'b0;
		req(1'b0, 8'h04, 40'hf8_0000_0005, SPACE_IO, 64'h0000_0000_00ab_0000, 4'h5);
		req(1'b0, 8'h53, 40'hf8_0000_0001, SPACE_CFG, 64'h00ab_00cd_0000_ef01, 4'h6);
		for (int i = 7; i < 16; i++) req(1'b1, {5'h0, SZ_8B}, 40'hf8_0000_0008, SPACE_MEM32, 64'h0, 4'(i));
		#1;
		`CHK(req_ready, 1'b0)
		@(posedge clk);
		wr_credit_ret <= 1'b1;
		wr_credit_id <= 4'h5;
		@(posedge clk);
		wr_credit_ret <= 1'b0;
		req(1'b0, 8'hff, 40'hf8_0000_0010, SPACE_MEM64, 64'h0123_4567_89ab_cdef, 4'h5);
	endtask
	task automatic t_rsps;
		logic [127:0] d;
		d = 128'habcd_ef01_2345_6789_0123_4567_89ab_cdef;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			rsp_valid <= 1'b1;
			rsp_size <= 3'(i);
			rsp_data <= d;
			rsp_credit <= 4'(i);
			@(posedge clk);
			rsp_valid <= 1'b0;
			#1;
			`CHK(ret_valid, 1'b1)
			`CHK(ret_thread, 6'h15)
			`CHK(ret_data, i == 4 ? d : {2{d[127:64]}})
		end
		`CHK(req_ready, 1'b1)
	endtask
	task automatic t_ints;
		logic [15:0] tags [4];
		tags = '{16'h7802, 16'h0006, 16'hfff9, 16'h4804};
		foreach (tags[i]) begin
			@(posedge clk);
			int_valid <= 1'b1;
			int_tag <= tags[i];
		end
		// fifth packet offered while the queue is full
		@(posedge clk);
		int_tag <= 16'hffff;
		@(posedge clk);
		int_valid <= 1'b0;
		#1;
		`CHK(int_ready, 1'b0)
		`CHK(int_pending, 1'b1)
		foreach (tags[i]) begin
			@(posedge clk);
			int_decide <= 1'b1;
			int_accept <= i[0];
			@(posedge clk);
			int_decide <= 1'b0;
			#1;
			`CHK(int_ack, i[0])
			`CHK(int_nack, !i[0])
			`CHK(int_ack_tag, {tags[i][14:11], tags[i][2:1]})
		end
		`CHK(int_pending, 1'b0)
		`CHK(int_ready, 1'b1)
	endtask
	// ====
	// main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{arst_n, req_valid, req_is_read, slow, rsp_valid, wr_credit_ret, int_valid} = '0;
		{int_accept, int_decide, req_addr, req_size, req_wdata, rsp_data, rsp_size} = '0;
		{rsp_credit, wr_credit_id, int_tag, req_buf_id} = '0;
		req_space = SPACE_MEM64;
		req_thread = 6'h2a;
		rsp_thread = 6'h15;
		addr_mask = MASK;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_reqs();
		t_rsps();
		t_ints();
		end_sim();
	end
endmodule
`default_nettype wire
